//--- hw/amd_pkg.sv
// Constants, enumerations and carrier structs for the addressing mode decoder.
// Assumes an external opcode table classifies each opcode byte into mode, kind and group.
package amd_pkg;

    // ========================================================================
    // Instruction set figures
    // ========================================================================
    localparam int unsigned AMD_INSTR_COUNT = 63;
    localparam int unsigned AMD_GROUP_COUNT = 13;

    // ========================================================================
    // Prefix bytes
    // ========================================================================
    localparam logic [7:0] AMD_Y_SELECT_PREFIX     = 8'h90;
    localparam logic [7:0] AMD_INDIRECT_Y_PREFIX   = 8'h91;
    localparam logic [7:0] AMD_INDIRECT_SEL_PREFIX = 8'h92;

    // ========================================================================
    // Reset values and fixed levels
    // ========================================================================
    localparam logic [1:0] AMD_MASK_LEVEL_SET   = 2'h3;
    localparam logic [1:0] AMD_MASK_LEVEL_RESET = 2'h0;
    localparam logic [1:0] AMD_MASK_RESET_VALUE = 2'h3;
    localparam logic [2:0] AMD_LEN_ONE          = 3'h1;
    localparam logic [15:0] AMD_PTR_STEP        = 16'h0001;

    // ========================================================================
    // Addressing modes
    // ========================================================================
    typedef enum logic [3:0] {
        AMD_INH    = 4'h0,
        AMD_IMM    = 4'h1,
        AMD_DIR_S  = 4'h2,
        AMD_DIR_L  = 4'h3,
        AMD_IDX_0  = 4'h4,
        AMD_IDX_S  = 4'h5,
        AMD_IDX_L  = 4'h6,
        AMD_IND_S  = 4'h7,
        AMD_IND_L  = 4'h8,
        AMD_IIDX_S = 4'h9,
        AMD_IIDX_L = 4'ha,
        AMD_REL_D  = 4'hb,
        AMD_REL_I  = 4'hc
    } amd_mode_type;

    // ========================================================================
    // Operation kinds that matter to the decoder
    // ========================================================================
    typedef enum logic [2:0] {
        AMD_K_LONG_OK    = 3'h0,
        AMD_K_SHORT_ONLY = 3'h1,
        AMD_K_MASK_SET   = 3'h2,
        AMD_K_MASK_RESET = 3'h3,
        AMD_K_WAIT       = 3'h4,
        AMD_K_HALT       = 3'h5,
        AMD_K_OTHER      = 3'h6
    } amd_kind_type;

    // ========================================================================
    // Carriers
    // ========================================================================
    typedef struct packed {
        amd_mode_type mode;
        amd_kind_type kind;
        logic [3:0]   group;
    } amd_info_type;

    typedef struct packed {
        logic [15:0]  ea;
        logic [7:0]   imm;
        logic [15:0]  pc_target;
        logic [2:0]   length;
        amd_mode_type mode;
        logic [3:0]   group;
        logic         use_y;
        logic         has_ea;
        logic         is_imm;
        logic         is_branch;
        logic         illegal;
    } amd_result_type;

endpackage

//--- hw/amd_decode.sv
// Addressing mode decoder: consumes prefix, opcode and operand bytes, fetches
// pointers from memory and delivers the effective address or branch target.
// Assumes one outstanding memory read, with data returned on rd_valid.
//
// Contract
// - Inherent instructions are one byte; no operand byte is fetched.
// - Immediate takes one byte after the opcode as the operand value.
// - Short direct takes one address byte, reaching 00 to FF.
// - Long direct takes a 16-bit address from the two following bytes.
// - Indexed address is the unsigned sum of X or Y and the offset.
// - Indexed without offset fetches nothing and uses the index alone.
// - Short indexed adds a one-byte offset; the sum reaches 1FE untruncated.
// - Long indexed adds the index to a 16-bit offset of two bytes.
// - Indirect modes read the operand address from the pointer location.
// - Short indirect reads a one-byte pointer, address within 00 to FF.
// - Long indirect forms read a 16-bit pointer from a one-byte location.
// - Indirect-indexed address is the fetched pointer plus X or Y.
// - Short indirect-indexed adds index to a byte pointer, up to 1FE.
// - Relative mode adds a sign-extended 8-bit offset to the PC.
// - Direct relative takes the displacement from the next byte.
// - Indirect relative reads the displacement from the addressed memory.
// - Clear, shift, bit, call and similar accept only short forms.
// - Load, compare, logic and arithmetic accept long and short forms.
// - Mask set places mask level 3; mask reset places level 0.
// - Wait enters low power until interrupt; halt stops the oscillator.
// - The set holds 63 instructions in 13 functional groups.
// - Y-select prefix swaps X for Y in X-based instructions.
// - Indirect-select prefix turns direct forms indirect, X indexed indirect.
// - Indirect-Y prefix turns X indirect-indexed into Y indirect-indexed.
`timescale 1ns/1ps

module amd_decode
    import amd_pkg::*;
(
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           resetn,
    // Instruction byte stream
    input  wire logic           fetch_valid,
    input  wire logic [7:0]     fetch_byte,
    input  wire amd_info_type   fetch_info,
    input  wire logic [15:0]    fetch_pc,
    output logic                fetch_ready,
    // Index registers
    input  wire logic [7:0]     index_x,
    input  wire logic [7:0]     index_y,
    // Memory read port
    output logic                rd_req,
    output logic [15:0]         rd_addr,
    input  wire logic           rd_valid,
    input  wire logic [7:0]     rd_data,
    // Decoded result
    output logic                result_valid,
    output amd_result_type      result,
    // Core control
    input  wire logic           irq_pending,
    output logic [1:0]          mask_level,
    output logic                wait_mode,
    output logic                halt_mode
);

    // ========================================================================
    // State
    // ========================================================================
    typedef enum logic [4:0] {
        S_OPC   = 5'h01,
        S_OPND1 = 5'h02,
        S_OPND2 = 5'h04,
        S_MEM1  = 5'h08,
        S_MEM2  = 5'h10
    } amd_state_type;

    amd_state_type  state_reg, state_next;
    amd_mode_type   mode_reg, mode_next;
    amd_kind_type   kind_reg, kind_next;
    logic [3:0]     group_reg, group_next;
    logic           pre_y_reg, pre_y_next;
    logic           pre_ind_reg, pre_ind_next;
    logic           pre_iy_reg, pre_iy_next;
    logic           use_y_reg, use_y_next;
    logic [7:0]     idx_reg, idx_next;
    logic [7:0]     hi_reg, hi_next;
    logic [7:0]     ptr_reg, ptr_next;
    logic [2:0]     len_reg, len_next;
    logic [15:0]    pc_reg, pc_next;
    logic [1:0]     mask_reg, mask_next;
    logic           wait_reg, wait_next;
    logic           halt_reg, halt_next;
    logic           ready_reg, ready_next;
    logic           rd_req_reg, rd_req_next;
    logic [15:0]    rd_addr_reg, rd_addr_next;
    logic           res_valid_reg, res_valid_next;
    amd_result_type result_reg, result_next;

    // ========================================================================
    // Prefix remapping
    // ========================================================================
    function automatic amd_mode_type remap(input amd_mode_type m, input logic p_ind,
                                           input logic p_iy);
        amd_mode_type r;
        r = m;
        if (p_ind) begin
            case (m)
                AMD_DIR_S: r = AMD_IND_S;
                AMD_DIR_L: r = AMD_IND_L;
                AMD_IDX_S: r = AMD_IIDX_S;
                AMD_IDX_L: r = AMD_IIDX_L;
                AMD_REL_D: r = AMD_REL_I;
                default:   r = m;
            endcase
        end
        if (p_iy) begin
            case (m)
                AMD_IDX_S, AMD_IIDX_S: r = AMD_IIDX_S;
                AMD_IDX_L, AMD_IIDX_L: r = AMD_IIDX_L;
                default:               r = m;
            endcase
        end
        return r;
    endfunction

    function automatic logic is_long(input amd_mode_type m);
        return (m == AMD_DIR_L) || (m == AMD_IDX_L) || (m == AMD_IND_L) || (m == AMD_IIDX_L);
    endfunction

    // ========================================================================
    // Next state
    // ========================================================================
    logic           fin;
    logic [15:0]    ea_v;
    logic [7:0]     imm_v;
    logic [15:0]    tgt_v;
    logic           has_ea_v;
    logic           is_imm_v;
    logic           br_v;
    logic [7:0]     disp_v;
    amd_mode_type   m_v;

    always_comb begin
        state_next     = state_reg;
        mode_next      = mode_reg;
        kind_next      = kind_reg;
        group_next     = group_reg;
        pre_y_next     = pre_y_reg;
        pre_ind_next   = pre_ind_reg;
        pre_iy_next    = pre_iy_reg;
        use_y_next     = use_y_reg;
        idx_next       = idx_reg;
        hi_next        = hi_reg;
        ptr_next       = ptr_reg;
        len_next       = len_reg;
        pc_next        = pc_reg;
        mask_next      = mask_reg;
        wait_next      = wait_reg;
        halt_next      = halt_reg;
        rd_req_next    = 1'b0;
        rd_addr_next   = rd_addr_reg;
        res_valid_next = 1'b0;
        result_next    = result_reg;
        fin            = 1'b0;
        ea_v           = 16'h0000;
        imm_v          = 8'h00;
        has_ea_v       = 1'b0;
        is_imm_v       = 1'b0;
        br_v           = 1'b0;
        disp_v         = 8'h00;
        m_v            = remap(fetch_info.mode, pre_ind_reg, pre_iy_reg);

        // An interrupt ends both low power states; a new entry in the same cycle wins.
        if (irq_pending) begin
            wait_next = 1'b0;
            halt_next = 1'b0;
        end

        case (state_reg)
            S_OPC: begin
                if (fetch_valid && ready_reg) begin
                    len_next = len_reg + AMD_LEN_ONE;
                    if (len_reg == 3'h0) begin
                        pc_next = fetch_pc;
                    end
                    if (fetch_byte == AMD_Y_SELECT_PREFIX) begin
                        pre_y_next = 1'b1;
                    end else if (fetch_byte == AMD_INDIRECT_SEL_PREFIX) begin
                        pre_ind_next = 1'b1;
                    end else if (fetch_byte == AMD_INDIRECT_Y_PREFIX) begin
                        pre_iy_next = 1'b1;
                    end else begin
                        mode_next  = m_v;
                        kind_next  = fetch_info.kind;
                        group_next = fetch_info.group;
                        use_y_next = pre_y_reg || pre_iy_reg;
                        idx_next   = (pre_y_reg || pre_iy_reg) ? index_y : index_x;
                        if (m_v == AMD_INH) begin
                            fin = 1'b1;
                            case (fetch_info.kind)
                                AMD_K_MASK_SET:   mask_next = AMD_MASK_LEVEL_SET;
                                AMD_K_MASK_RESET: mask_next = AMD_MASK_LEVEL_RESET;
                                AMD_K_WAIT:       wait_next = 1'b1;
                                AMD_K_HALT:       halt_next = 1'b1;
                                default:          mask_next = mask_reg;
                            endcase
                        end else if (m_v == AMD_IDX_0) begin
                            fin      = 1'b1;
                            has_ea_v = 1'b1;
                            ea_v     = {8'h00, idx_next};
                        end else begin
                            state_next = S_OPND1;
                        end
                    end
                end
            end
            S_OPND1: begin
                if (fetch_valid && ready_reg) begin
                    len_next = len_reg + AMD_LEN_ONE;
                    case (mode_reg)
                        AMD_IMM: begin
                            fin      = 1'b1;
                            is_imm_v = 1'b1;
                            imm_v    = fetch_byte;
                        end
                        AMD_DIR_S: begin
                            fin      = 1'b1;
                            has_ea_v = 1'b1;
                            ea_v     = {8'h00, fetch_byte};
                        end
                        AMD_IDX_S: begin
                            fin      = 1'b1;
                            has_ea_v = 1'b1;
                            ea_v     = {8'h00, fetch_byte} + {8'h00, idx_reg};
                        end
                        AMD_REL_D: begin
                            fin    = 1'b1;
                            br_v   = 1'b1;
                            disp_v = fetch_byte;
                        end
                        AMD_DIR_L, AMD_IDX_L: begin
                            hi_next    = fetch_byte;
                            state_next = S_OPND2;
                        end
                        default: begin
                            ptr_next     = fetch_byte;
                            rd_req_next  = 1'b1;
                            rd_addr_next = {8'h00, fetch_byte};
                            state_next   = S_MEM1;
                        end
                    endcase
                end
            end
            S_OPND2: begin
                if (fetch_valid && ready_reg) begin
                    len_next = len_reg + AMD_LEN_ONE;
                    fin      = 1'b1;
                    has_ea_v = 1'b1;
                    if (mode_reg == AMD_IDX_L) begin
                        ea_v = {hi_reg, fetch_byte} + {8'h00, idx_reg};
                    end else begin
                        ea_v = {hi_reg, fetch_byte};
                    end
                end
            end
            S_MEM1: begin
                if (rd_valid) begin
                    case (mode_reg)
                        AMD_IND_S: begin
                            fin      = 1'b1;
                            has_ea_v = 1'b1;
                            ea_v     = {8'h00, rd_data};
                        end
                        AMD_IIDX_S: begin
                            fin      = 1'b1;
                            has_ea_v = 1'b1;
                            ea_v     = {8'h00, rd_data} + {8'h00, idx_reg};
                        end
                        AMD_REL_I: begin
                            fin    = 1'b1;
                            br_v   = 1'b1;
                            disp_v = rd_data;
                        end
                        default: begin
                            hi_next      = rd_data;
                            rd_req_next  = 1'b1;
                            rd_addr_next = {8'h00, ptr_reg} + AMD_PTR_STEP;
                            state_next   = S_MEM2;
                        end
                    endcase
                end
            end
            S_MEM2: begin
                if (rd_valid) begin
                    fin      = 1'b1;
                    has_ea_v = 1'b1;
                    if (mode_reg == AMD_IIDX_L) begin
                        ea_v = {hi_reg, rd_data} + {8'h00, idx_reg};
                    end else begin
                        ea_v = {hi_reg, rd_data};
                    end
                end
            end
            default: begin
                state_next = S_OPC;
            end
        endcase

        // Target is taken from the end of the instruction, which is the PC of the next one.
        tgt_v = pc_next + {13'h0000, len_next} + {{8{disp_v[7]}}, disp_v};

        if (fin) begin
            res_valid_next        = 1'b1;
            result_next.ea        = ea_v;
            result_next.imm       = imm_v;
            result_next.pc_target = br_v ? tgt_v : 16'h0000;
            result_next.length    = len_next;
            result_next.mode      = mode_next;
            result_next.group     = group_next;
            result_next.use_y     = use_y_next;
            result_next.has_ea    = has_ea_v;
            result_next.is_imm    = is_imm_v;
            result_next.is_branch = br_v;
            // Long forms are refused for short-only kinds; groups from 13 up are refused in every form.
            result_next.illegal   = ((kind_next == AMD_K_SHORT_ONLY) && is_long(mode_next))
                                    || (group_next >= 4'(AMD_GROUP_COUNT));
            state_next   = S_OPC;
            len_next     = 3'h0;
            pre_y_next   = 1'b0;
            pre_ind_next = 1'b0;
            pre_iy_next  = 1'b0;
        end

        // The stream stalls while low power holds, so no byte is lost on wakeup.
        ready_next = ((state_next == S_OPC) || (state_next == S_OPND1) ||
                      (state_next == S_OPND2)) && !wait_next && !halt_next;
    end

    // ========================================================================
    // Registers
    // ========================================================================
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg     <= S_OPC;
            mode_reg      <= AMD_INH;
            kind_reg      <= AMD_K_OTHER;
            group_reg     <= 4'h0;
            pre_y_reg     <= 1'b0;
            pre_ind_reg   <= 1'b0;
            pre_iy_reg    <= 1'b0;
            use_y_reg     <= 1'b0;
            idx_reg       <= 8'h00;
            hi_reg        <= 8'h00;
            ptr_reg       <= 8'h00;
            len_reg       <= 3'h0;
            pc_reg        <= 16'h0000;
            mask_reg      <= AMD_MASK_RESET_VALUE;
            wait_reg      <= 1'b0;
            halt_reg      <= 1'b0;
            ready_reg     <= 1'b0;
            rd_req_reg    <= 1'b0;
            rd_addr_reg   <= 16'h0000;
            res_valid_reg <= 1'b0;
            result_reg    <= '0;
        end else begin
            state_reg     <= state_next;
            mode_reg      <= mode_next;
            kind_reg      <= kind_next;
            group_reg     <= group_next;
            pre_y_reg     <= pre_y_next;
            pre_ind_reg   <= pre_ind_next;
            pre_iy_reg    <= pre_iy_next;
            use_y_reg     <= use_y_next;
            idx_reg       <= idx_next;
            hi_reg        <= hi_next;
            ptr_reg       <= ptr_next;
            len_reg       <= len_next;
            pc_reg        <= pc_next;
            mask_reg      <= mask_next;
            wait_reg      <= wait_next;
            halt_reg      <= halt_next;
            ready_reg     <= ready_next;
            rd_req_reg    <= rd_req_next;
            rd_addr_reg   <= rd_addr_next;
            res_valid_reg <= res_valid_next;
            result_reg    <= result_next;
        end
    end

    assign fetch_ready  = ready_reg;
    assign rd_req       = rd_req_reg;
    assign rd_addr      = rd_addr_reg;
    assign result_valid = res_valid_reg;
    assign result       = result_reg;
    assign mask_level   = mask_reg;
    assign wait_mode    = wait_reg;
    assign halt_mode    = halt_reg;

endmodule

//--- sim/amd_checker.sv
// Port checker for the addressing mode decoder.
// Assumes it is bound to amd_decode with one clock and a synchronous reset.
`timescale 1ns/1ps

module amd_checker
    import amd_pkg::*;
(
    // Clock and reset
    input wire logic           clk,
    input wire logic           resetn,
    // Watched signals
    input wire logic           rd_req,
    input wire logic [15:0]    rd_addr,
    input wire logic           rd_valid,
    input wire logic           result_valid,
    input wire amd_result_type result,
    input wire logic           irq_pending,
    input wire logic [1:0]     mask_level,
    input wire logic           wait_mode
);
    // ========================================================================
    // Properties
    // ========================================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // A first read answered, then the follow-up read of the same pointer.
    sequence s_read_done;
        rd_valid ##1 rd_req;
    endsequence

    a_inh_one: assert property (result_valid && result.mode == AMD_INH
        && !result.use_y |-> result.length == 3'h1) else $error("inherent length wrong");
    a_imm_two: assert property (result_valid && result.is_imm
        && !result.use_y |-> result.length == 3'h2) else $error("immediate length wrong");
    a_idx_zero: assert property (result_valid && result.mode == AMD_IDX_0
        |-> result.ea[15:8] == 8'h00) else $error("no offset address out of page");
    a_idx_range: assert property (result_valid && (result.mode == AMD_IDX_S
        || result.mode == AMD_IIDX_S) |-> result.ea <= 16'h01fe) else $error("short sum range");
    a_ptr_step: assert property (s_read_done
        |-> rd_addr == $past(rd_addr) + 16'h0001) else $error("second read address wrong");
    a_rd_pulse: assert property (rd_req |=> !rd_req) else $error("read request too long");
    a_mask_cause: assert property ($changed(mask_level)
        |-> result_valid && mask_level inside {2'h3, 2'h0}) else $error("mask change wrong");
    a_wake_irq: assert property (wait_mode && irq_pending
        |=> !wait_mode) else $error("wait not left on interrupt");
endmodule

//--- sim/tb_top.sv
// Self-checking bench for the addressing mode decoder.
// Assumes amd_pkg and amd_checker are compiled first; the bench plays fetch and memory.
`timescale 1ns/1ps

module tb_top
    import amd_pkg::*;
;
    logic           clk = 1'b0;
    logic           resetn = 1'b0;
    logic           fetch_valid = 1'b0;
    logic [7:0]     fetch_byte = 8'h00;
    amd_info_type   fetch_info = '0;
    logic [15:0]    fetch_pc = 16'h0000;
    logic [7:0]     index_x = 8'h00;
    logic [7:0]     index_y = 8'h00;
    logic           rd_valid = 1'b0;
    logic [7:0]     rd_data = 8'h00;
    logic           irq_pending = 1'b0;
    logic [3:0]     grp = 4'h0;
    logic           fetch_ready, rd_req, result_valid, wait_mode, halt_mode;
    logic [15:0]    rd_addr;
    logic [1:0]     mask_level;
    amd_result_type result;
    int             err_count = 0;
    int             samples_checked = 0;

    amd_decode i_dut (.clk(clk), .resetn(resetn), .fetch_valid(fetch_valid),
        .fetch_byte(fetch_byte), .fetch_info(fetch_info), .fetch_pc(fetch_pc),
        .fetch_ready(fetch_ready), .index_x(index_x), .index_y(index_y), .rd_req(rd_req),
        .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data), .result_valid(result_valid),
        .result(result), .irq_pending(irq_pending), .mask_level(mask_level),
        .wait_mode(wait_mode), .halt_mode(halt_mode));

    // ========================================================================
    // Helpers
    // ========================================================================
    initial forever #50 clk = ~clk;

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic tmo();
        err_count++;
        summarize();
    endtask

    // Holds the byte offered until an edge samples fetch_ready high.
    task automatic put(input logic [7:0] b, input amd_info_type inf);
        int n;
        fetch_valid = 1'b1;
        fetch_byte = b;
        fetch_info = inf;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (fetch_ready === 1'b1) break;
        end
        #1;
        if (n == 20) tmo();
    endtask

    task automatic op(input logic [7:0] pre, input amd_mode_type m, input amd_kind_type k,
                      input logic [15:0] v, input int nb);
        if (pre != 8'h00) put(pre, '0);
        put(8'h01, '{m, k, grp});
        if (nb == 2) put(v[15:8], '0);
        if (nb > 0) put(v[7:0], '0);
    endtask

    // Answers one read after a stall; the data line is inverted once released.
    task automatic mem(input logic [15:0] a, input logic [7:0] d);
        int n;
        for (n = 0; n < 20 && rd_req !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        if (n == 20) tmo();
        chk("rd_addr", rd_addr, a);
        repeat (3) @(posedge clk);
        #1;
        rd_valid = 1'b1;
        rd_data = d;
        @(posedge clk);
        #1;
        rd_valid = 1'b0;
        rd_data = ~d;
    endtask

    task automatic res(input logic [2:0] len);
        int n;
        for (n = 0; n < 20 && result_valid !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        if (n == 20) tmo();
        chk("length", result.length, len);
    endtask

    // ========================================================================
    // Scenarios
    // ========================================================================
    task automatic t_inherent();
        grp = 4'hc;
        op(8'h00, AMD_INH, AMD_K_MASK_RESET, 16'h0000, 0);
        res(3'h1);
        chk("mask", mask_level, 2'h0);
        op(8'h00, AMD_INH, AMD_K_MASK_SET, 16'h0000, 0);
        res(3'h1);
        chk("mask", mask_level, 2'h3);
        chk("group", result.group, 4'hc);
        grp = 4'hb;
        op(8'h00, AMD_INH, AMD_K_WAIT, 16'h0000, 0);
        res(3'h1);
        chk("wait", wait_mode, 1'b1);
        irq_pending = 1'b1;
        repeat (1) @(posedge clk);
        #1;
        chk("wait", wait_mode, 1'b0);
        op(8'h00, AMD_INH, AMD_K_HALT, 16'h0000, 0);
        res(3'h1);
        chk("halt", halt_mode, 1'b1);
        @(posedge clk);
        #1;
        chk("halt", halt_mode, 1'b0);
        irq_pending = 1'b0;
        grp = 4'h0;
    endtask
    task automatic t_direct();
        op(8'h00, AMD_IMM, AMD_K_LONG_OK, 16'h0055, 1);
        res(3'h2);
        chk("imm", result.imm, 8'h55);
        op(8'h00, AMD_DIR_L, AMD_K_LONG_OK, 16'h1234, 2);
        res(3'h3);
        chk("ea", result.ea, 16'h1234);
        chk("illegal", result.illegal, 1'b0);
        op(8'h00, AMD_DIR_S, AMD_K_SHORT_ONLY, 16'h00c3, 1);
        res(3'h2);
        chk("ea", result.ea, 16'h00c3);
        op(8'h00, AMD_DIR_L, AMD_K_SHORT_ONLY, 16'h1234, 2);
        res(3'h3);
        chk("illegal", result.illegal, 1'b1);
        grp = 4'hd;
        op(8'h00, AMD_IMM, AMD_K_LONG_OK, 16'h0001, 1);
        res(3'h2);
        chk("illegal", result.illegal, 1'b1);
        grp = 4'h0;
    endtask
    task automatic t_indexed();
        index_x = 8'hff;
        index_y = 8'h01;
        op(8'h00, AMD_IDX_S, AMD_K_LONG_OK, 16'h00ff, 1);
        res(3'h2);
        chk("ea", result.ea, 16'h01fe);
        op(8'h90, AMD_IDX_L, AMD_K_LONG_OK, 16'hfff0, 2);
        res(3'h4);
        chk("ea", result.ea, 16'hfff1);
        op(8'h00, AMD_IDX_0, AMD_K_LONG_OK, 16'h0000, 0);
        res(3'h1);
        chk("ea", result.ea, 16'h00ff);
    endtask
    task automatic t_indirect();
        op(8'h92, AMD_DIR_S, AMD_K_SHORT_ONLY, 16'h0033, 1);
        mem(16'h0033, 8'hc5);
        res(3'h3);
        chk("ea", result.ea, 16'h00c5);
        index_x = 8'h10;
        op(8'h92, AMD_IDX_L, AMD_K_LONG_OK, 16'h0040, 1);
        mem(16'h0040, 8'h12);
        mem(16'h0041, 8'h34);
        res(3'h3);
        chk("ea", result.ea, 16'h1244);
        chk("mode", result.mode, AMD_IIDX_L);
        index_y = 8'hff;
        op(8'h91, AMD_IDX_S, AMD_K_LONG_OK, 16'h00ff, 1);
        mem(16'h00ff, 8'hff);
        res(3'h3);
        chk("ea", result.ea, 16'h01fe);
        chk("use_y", result.use_y, 1'b1);
    endtask

    task automatic t_relative();
        fetch_pc = 16'h0100;
        op(8'h00, AMD_REL_D, AMD_K_OTHER, 16'h0080, 1);
        res(3'h2);
        chk("target", result.pc_target, 16'h0082);
        chk("flags", {result.has_ea, result.is_imm, result.is_branch}, 3'h1);
        fetch_pc = 16'h0200;
        op(8'h92, AMD_REL_D, AMD_K_OTHER, 16'h0020, 1);
        mem(16'h0020, 8'h05);
        res(3'h3);
        chk("target", result.pc_target, 16'h0208);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        #1;
        resetn = 1'b1;
        chk("mask", mask_level, 2'h3);
        @(posedge clk);
        #1;
        t_inherent();
        t_direct();
        t_indexed();
        t_indirect();
        t_relative();
        summarize();
    end
endmodule

bind amd_decode amd_checker i_chk (.clk(clk), .resetn(resetn), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_valid(rd_valid), .result_valid(result_valid), .result(result),
    .irq_pending(irq_pending), .mask_level(mask_level), .wait_mode(wait_mode));
